/* File: logic/exec_defines.vh */
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// Return opcodes
`define OPC_RETURN_RESTORE 16'h4e77
`define OPC_RETURN_SUB 16'h4e75

// Opcode classes and fixed fields
`define CLASS_DECIMAL 4'h8
`define DECIMAL_FIXED 5'h10
`define CLASS_SETCOND 4'h5
`define CLASS_SUBTRACT 4'h9
`define SIZE_FIELD_ALL 2'h3

// Address mode codes
`define MODE_DATA_REG 3'h0
`define MODE_ADDR_REG 3'h1
`define MODE_INDIRECT 3'h2
`define MODE_INDEX 3'h6
`define MODE_EXTENDED 3'h7
`define EXT_ABS_LONG 3'h1
`define EXT_IMMEDIATE 3'h4

// Operand sizes
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

// Status register layout and reset values
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_X 4
`define FLAG_BYTE_MASK 8'h1f
`define SR_RESET 16'h0000
`define PC_RESET 32'h00000000

// Register file index of the active stack pointer
`define STACK_POINTER_INDEX 4'hf

// Stack pointer steps
`define STEP_FLAG_WORD 32'h00000002
`define STEP_LONG_WORD 32'h00000004

// Set-on-condition read before write
`define SETCOND_READ_FIRST 1'b1

`endif

/* File: logic/exec_register_file.v */
module exec_register_file (
    input wire i_clk, // Clock
    input wire i_srst, // Reset
    input wire i_we, // Write strobe
    input wire [3:0] i_waddr, // Write index
    input wire [31:0] i_wdata, // Write data
    input wire [3:0] i_raddr, // Read index
    output reg [31:0] o_rdata // Registered read data
);

    // Data registers 0..7, address registers 8..15
    reg [31:0] mem [0:15];

    // Write port
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read port
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule // exec_register_file

/* File: logic/return_bcd_setcond_subtract_exec.v */
// Behaviour
// - Flag return: pop flags, stack +2, pop counter, stack +4.
// - Flag return changes only the flag byte.
// - Subroutine return: pop counter, stack +4, flags kept.
// - Decimal subtract: destination minus source minus extend.
// - Mode bit: 0 data, 1 predecremented address registers.
// - Decimal borrow sets carry and extend.
// - Nonzero decimal result clears zero, else kept.
// - Set-on-condition writes ff or 00, flags kept.
// - Sixteen condition tests.
// - Set-on-condition destination data alterable.
// - Memory destination read before write.
// - Subtract on a data register, three sizes.
// - Operation mode gives size and destination.
// - Subtract sets N, Z, V, C; extend copies carry.
// - Subtract source accepts every mode up to immediate; extended codes above immediate illegal.
// - Byte subtract from address register illegal.
// - Subtract destination memory alterable.
`include "exec_defines.vh"

module return_bcd_setcond_subtract_exec (
    input wire I_MCLK, // Clock
    input wire I_SRST, // Reset
    input wire I_START, // Start pulse
    input wire [15:0] I_OPCODE, // Opcode
    input wire [31:0] I_EA_ADDR, // Operand address
    input wire [31:0] I_IMM_DATA, // Immediate source
    input wire I_SR_WE, // Status load
    input wire [15:0] I_SR_WDATA, // Status value
    input wire I_REG_WE, // Register write
    input wire [3:0] I_REG_ADDR, // Register index
    input wire [31:0] I_REG_WDATA, // Register data
    output wire [31:0] O_REG_RDATA, // Register read data
    output wire O_MEM_REQ, // Memory request
    output reg O_MEM_WE, // Memory write
    output reg [1:0] O_MEM_SIZE, // Access size
    output reg [31:0] O_MEM_ADDR, // Memory address
    output reg [31:0] O_MEM_WDATA, // Write data
    input wire I_MEM_ACK, // Acknowledge
    input wire [31:0] I_MEM_RDATA, // Read data
    output wire O_BUSY, // Busy
    output reg O_DONE, // Done pulse
    output reg O_ILLEGAL, // Illegal pulse
    output reg [31:0] O_PC, // Program counter
    output reg [15:0] O_SR // Status register
);

    ////////////////////////////////////////////////////////////////////////////
    // States and instruction kinds
    localparam ST_IDLE = 4'h0;
    localparam ST_RD1 = 4'h1;
    localparam ST_RD2 = 4'h2;
    localparam ST_LAT2 = 4'h3;
    localparam ST_MEMA = 4'h4;
    localparam ST_MEMB = 4'h5;
    localparam ST_EXEC = 4'h6;
    localparam ST_WMEM = 4'h7;
    localparam ST_WRA = 4'h8;
    localparam ST_WRB = 4'h9;

    localparam K_BAD = 3'h0;
    localparam K_RTRF = 3'h1;
    localparam K_RETS = 3'h2;
    localparam K_DSUB = 3'h3;
    localparam K_SETC = 3'h4;
    localparam K_SUBT = 3'h5;

    reg [3:0] state;
    reg [2:0] kind;
    reg [15:0] op;
    reg [1:0] size;
    reg [31:0] ea_addr;
    reg [31:0] imm;
    reg [31:0] va1;
    reg [31:0] va2;
    reg [31:0] op_s;
    reg [31:0] op_d;
    reg [31:0] result;

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions

    // Memory alterable address modes
    function mem_alt;
        input [2:0] m;
        input [2:0] r;
        begin
            mem_alt = (m >= `MODE_INDIRECT && m <= `MODE_INDEX) ||
                      (m == `MODE_EXTENDED && r <= `EXT_ABS_LONG);
        end
    endfunction

    // Instruction kind with legality
    function [2:0] kind_of;
        input [15:0] o;
        reg [2:0] m;
        reg [2:0] r;
        begin
            m = o[5:3];
            r = o[2:0];
            kind_of = K_BAD;
            if (o == `OPC_RETURN_RESTORE) begin
                kind_of = K_RTRF;
            end else if (o == `OPC_RETURN_SUB) begin
                kind_of = K_RETS;
            end else if (o[15:12] == `CLASS_DECIMAL && o[8:4] == `DECIMAL_FIXED) begin
                kind_of = K_DSUB;
            end else if (o[15:12] == `CLASS_SETCOND && o[7:6] == `SIZE_FIELD_ALL) begin
                if (m == `MODE_DATA_REG || mem_alt(m, r)) begin
                    kind_of = K_SETC;
                end
            end else if (o[15:12] == `CLASS_SUBTRACT && o[7:6] != `SIZE_FIELD_ALL) begin
                if (o[8]) begin
                    if (mem_alt(m, r)) begin
                        kind_of = K_SUBT;
                    end
                end else if (!(m == `MODE_ADDR_REG && o[7:6] == `SZ_BYTE) &&
                             !(m == `MODE_EXTENDED && r > `EXT_IMMEDIATE)) begin
                    kind_of = K_SUBT;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic and condition functions

    // Sized subtract, flags and result
    function [35:0] sub_calc;
        input [1:0] sz;
        input [31:0] d;
        input [31:0] s;
        reg [4:0] sh;
        reg [31:0] da;
        reg [31:0] sa;
        reg [32:0] diff;
        reg [31:0] r;
        begin
            sh = (sz == `SZ_BYTE) ? 5'h18 : ((sz == `SZ_WORD) ? 5'h10 : 5'h00);
            da = d << sh;
            sa = s << sh;
            diff = {1'b0, da} - {1'b0, sa};
            r = diff[31:0];
            sub_calc = {r[31], r == 32'h00000000, (da[31] ^ sa[31]) & (da[31] ^ r[31]), diff[32], r >> sh};
        end
    endfunction

    // Decimal subtract, borrow and byte
    function [8:0] bcd_sub;
        input [7:0] d;
        input [7:0] s;
        input x;
        reg [8:0] diff;
        reg [9:0] t;
        reg lowb;
        reg borrow;
        begin
            diff = {1'b0, d} - {1'b0, s} - {8'h00, x};
            lowb = {1'b0, d[3:0]} < ({1'b0, s[3:0]} + {4'h0, x});
            t = {1'b0, diff} - (lowb ? 10'h006 : 10'h000);
            borrow = diff[8] | t[9];
            bcd_sub = {borrow, t[7:0] - (borrow ? 8'h60 : 8'h00)};
        end
    endfunction

    // Sixteen condition tests on the flag bits
    function cond_true;
        input [3:0] cc;
        input [4:0] f;
        reg c;
        reg v;
        reg z;
        reg n;
        begin
            c = f[`FLAG_C];
            v = f[`FLAG_V];
            z = f[`FLAG_Z];
            n = f[`FLAG_N];
            case (cc)
                4'h0: cond_true = 1'b1;
                4'h1: cond_true = 1'b0;
                4'h2: cond_true = ~c & ~z;
                4'h3: cond_true = c | z;
                4'h4: cond_true = ~c;
                4'h5: cond_true = c;
                4'h6: cond_true = ~z;
                4'h7: cond_true = z;
                4'h8: cond_true = ~v;
                4'h9: cond_true = v;
                4'ha: cond_true = ~n;
                4'hb: cond_true = n;
                4'hc: cond_true = ~(n ^ v);
                4'hd: cond_true = n ^ v;
                4'he: cond_true = ~z & ~(n ^ v);
                default: cond_true = z | (n ^ v);
            endcase
        end
    endfunction

    // Merge a sized result into a register value
    function [31:0] merge_sized;
        input [1:0] sz;
        input [31:0] old;
        input [31:0] nv;
        begin
            case (sz)
                `SZ_BYTE: merge_sized = {old[31:8], nv[7:0]};
                `SZ_WORD: merge_sized = {old[31:16], nv[15:0]};
                default: merge_sized = nv;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Field decode and execution results
    wire mem_mode = op[3];
    wire ea_dest = op[8];
    wire [2:0] ea_mode = op[5:3];
    wire [2:0] ea_reg = op[2:0];
    wire src_is_reg = (ea_mode == `MODE_DATA_REG) || (ea_mode == `MODE_ADDR_REG);
    wire src_is_imm = (ea_mode == `MODE_EXTENDED) && (ea_reg == `EXT_IMMEDIATE);
    wire [35:0] sub_out = sub_calc(size, op_d, op_s);
    wire [8:0] bcd_out = bcd_sub(op_d[7:0], op_s[7:0], O_SR[`FLAG_X]);
    wire cond_hit = cond_true(op[11:8], O_SR[4:0]);

    // Operand read indices
    reg [3:0] ra1;
    reg [3:0] ra2;
    always @* begin
        ra1 = `STACK_POINTER_INDEX;
        ra2 = `STACK_POINTER_INDEX;
        case (kind)
            K_DSUB: begin
                ra1 = {mem_mode, op[2:0]};
                ra2 = {mem_mode, op[11:9]};
            end
            K_SETC: begin
                ra1 = {1'b0, ea_reg};
                ra2 = {1'b0, ea_reg};
            end
            K_SUBT: begin
                ra1 = {ea_mode[0], ea_reg};
                ra2 = {1'b0, op[11:9]};
            end
            default: begin
                ra1 = `STACK_POINTER_INDEX;
                ra2 = `STACK_POINTER_INDEX;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, idle and execution
    wire idle = (state == ST_IDLE);
    wire [31:0] rf_rdata;
    wire rf_we = idle ? I_REG_WE : (state == ST_WRA || state == ST_WRB);
    wire [3:0] rf_waddr = idle ? I_REG_ADDR : ((state == ST_WRA) ? ra1 : ra2);
    wire [31:0] wb_data = (kind == K_DSUB && mem_mode) ? va2 : merge_sized(size, op_d, result);
    wire [31:0] rf_wdata = idle ? I_REG_WDATA : ((state == ST_WRA) ? va1 : wb_data);
    wire [3:0] rf_raddr = idle ? I_REG_ADDR : ((state == ST_RD2) ? ra2 : ra1);

    exec_register_file u_regs (
        .i_clk(I_MCLK),
        .i_srst(I_SRST),
        .i_we(rf_we),
        .i_waddr(rf_waddr),
        .i_wdata(rf_wdata),
        .i_raddr(rf_raddr),
        .o_rdata(rf_rdata)
    );

    assign O_REG_RDATA = rf_rdata;
    assign O_BUSY = !idle;
    assign O_MEM_REQ = (state == ST_MEMA) || (state == ST_MEMB) || (state == ST_WMEM);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            state <= ST_IDLE;
            kind <= K_BAD;
            op <= 16'h0000;
            size <= `SZ_BYTE;
            ea_addr <= 32'h00000000;
            imm <= 32'h00000000;
            va1 <= 32'h00000000;
            va2 <= 32'h00000000;
            op_s <= 32'h00000000;
            op_d <= 32'h00000000;
            result <= 32'h00000000;
            O_MEM_WE <= 1'b0;
            O_MEM_SIZE <= `SZ_BYTE;
            O_MEM_ADDR <= 32'h00000000;
            O_MEM_WDATA <= 32'h00000000;
            O_DONE <= 1'b0;
            O_ILLEGAL <= 1'b0;
            O_PC <= `PC_RESET;
            O_SR <= `SR_RESET;
        end else begin
            O_DONE <= 1'b0;
            O_ILLEGAL <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (I_SR_WE) begin
                        O_SR <= I_SR_WDATA;
                    end
                    if (I_START) begin
                        op <= I_OPCODE;
                        ea_addr <= I_EA_ADDR;
                        imm <= I_IMM_DATA;
                        kind <= kind_of(I_OPCODE);
                        size <= (I_OPCODE[15:12] == `CLASS_SUBTRACT) ? I_OPCODE[7:6] : `SZ_BYTE;
                        if (kind_of(I_OPCODE) == K_BAD) begin
                            O_ILLEGAL <= 1'b1;
                        end else begin
                            state <= ST_RD1;
                        end
                    end
                end
                ST_RD1: begin
                    state <= ST_RD2;
                end
                ST_RD2: begin
                    va1 <= (kind == K_DSUB) ? rf_rdata - 32'h00000001 : rf_rdata;
                    op_s <= rf_rdata;
                    state <= ST_LAT2;
                end
                ST_LAT2: begin
                    va2 <= rf_rdata - 32'h00000001;
                    op_d <= rf_rdata;
                    O_MEM_WE <= 1'b0;
                    state <= ST_EXEC;
                    case (kind)
                        K_RTRF: begin
                            O_MEM_ADDR <= va1;
                            O_MEM_SIZE <= `SZ_WORD;
                            state <= ST_MEMA;
                        end
                        K_RETS: begin
                            O_MEM_ADDR <= va1;
                            O_MEM_SIZE <= `SZ_LONG;
                            state <= ST_MEMB;
                        end
                        K_DSUB: begin
                            if (mem_mode) begin
                                O_MEM_ADDR <= va1;
                                O_MEM_SIZE <= `SZ_BYTE;
                                state <= ST_MEMA;
                            end
                        end
                        K_SETC: begin
                            if (ea_mode != `MODE_DATA_REG && `SETCOND_READ_FIRST) begin
                                O_MEM_ADDR <= ea_addr;
                                O_MEM_SIZE <= `SZ_BYTE;
                                state <= ST_MEMB;
                            end
                        end
                        default: begin
                            O_MEM_ADDR <= ea_addr;
                            O_MEM_SIZE <= size;
                            if (ea_dest) begin
                                op_s <= rf_rdata;
                                state <= ST_MEMB;
                            end else if (src_is_imm) begin
                                op_s <= imm;
                            end else if (!src_is_reg) begin
                                state <= ST_MEMA;
                            end
                        end
                    endcase
                end
                ST_MEMA: begin
                    if (I_MEM_ACK) begin
                        op_s <= I_MEM_RDATA;
                        state <= ST_EXEC;
                        if (kind == K_RTRF) begin
                            O_SR[7:0] <= I_MEM_RDATA[7:0] & `FLAG_BYTE_MASK;
                            va1 <= va1 + `STEP_FLAG_WORD;
                            O_MEM_ADDR <= va1 + `STEP_FLAG_WORD;
                            O_MEM_SIZE <= `SZ_LONG;
                            state <= ST_MEMB;
                        end else if (kind == K_DSUB) begin
                            O_MEM_ADDR <= va2;
                            state <= ST_MEMB;
                        end
                    end
                end
                ST_MEMB: begin
                    if (I_MEM_ACK) begin
                        op_d <= I_MEM_RDATA;
                        state <= ST_EXEC;
                        if (kind == K_RTRF || kind == K_RETS) begin
                            O_PC <= I_MEM_RDATA;
                            va1 <= va1 + `STEP_LONG_WORD;
                            state <= ST_WRA;
                        end
                    end
                end
                ST_EXEC: begin
                    O_MEM_WE <= 1'b1;
                    O_MEM_ADDR <= ea_addr;
                    state <= ST_WRB;
                    case (kind)
                        K_DSUB: begin
                            result <= {24'h000000, bcd_out[7:0]};
                            O_MEM_WDATA <= {24'h000000, bcd_out[7:0]};
                            O_SR[`FLAG_C] <= bcd_out[8];
                            O_SR[`FLAG_X] <= bcd_out[8];
                            if (bcd_out[7:0] != 8'h00) begin
                                O_SR[`FLAG_Z] <= 1'b0;
                            end
                            if (mem_mode) begin
                                O_MEM_ADDR <= va2;
                                state <= ST_WMEM;
                            end
                        end
                        K_SETC: begin
                            result <= cond_hit ? 32'h000000ff : 32'h00000000;
                            O_MEM_WDATA <= cond_hit ? 32'h000000ff : 32'h00000000;
                            if (ea_mode != `MODE_DATA_REG) begin
                                state <= ST_WMEM;
                            end
                        end
                        default: begin
                            result <= sub_out[31:0];
                            O_MEM_WDATA <= sub_out[31:0];
                            O_SR[4:0] <= {sub_out[32], sub_out[35:32]};
                            if (ea_dest) begin
                                state <= ST_WMEM;
                            end
                        end
                    endcase
                end
                ST_WMEM: begin
                    if (I_MEM_ACK) begin
                        O_MEM_WE <= 1'b0;
                        if (kind == K_DSUB) begin
                            state <= ST_WRA;
                        end else begin
                            O_DONE <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WRA: begin
                    if (kind == K_DSUB) begin
                        state <= ST_WRB;
                    end else begin
                        O_DONE <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_WRB: begin
                    O_MEM_WE <= 1'b0;
                    O_DONE <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // return_bcd_setcond_subtract_exec

/* File: tb/exec_checker.sv */
module exec_checker (
    input wire logic I_MCLK, I_SRST, I_START, O_BUSY, O_DONE, O_ILLEGAL, O_MEM_REQ, O_MEM_WE, I_MEM_ACK,
    input wire logic [15:0] I_OPCODE, O_SR,
    input wire logic [1:0] O_MEM_SIZE,
    input wire logic [31:0] O_MEM_ADDR
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);
    logic [15:0] op;
    logic rd_seen;
    // Opcode in flight and read-before-write tracking
    always @(posedge I_MCLK) begin
        if (I_START && !O_BUSY) op <= I_OPCODE;
        if (I_START && !O_BUSY) rd_seen <= 1'b0;
        else if (O_MEM_REQ && I_MEM_ACK && !O_MEM_WE) rd_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    start_answer_a: assert property (I_START && !O_BUSY |-> ##[1:80] (O_DONE || O_ILLEGAL))
        else $error("start without answer");
    illegal_quiet_a: assert property (O_ILLEGAL |-> !O_DONE && !O_BUSY && !O_MEM_REQ)
        else $error("illegal opcode not quiet");
    req_hold_a: assert property (O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR))
        else $error("request dropped or moved");
    sr_upper_a: assert property (O_BUSY |=> $stable(O_SR[15:8]))
        else $error("upper status changed");
    flags_kept_a: assert property (O_BUSY && (op == 16'h4e75 || op[15:12] == 4'h5) |=> $stable(O_SR))
        else $error("flags changed");
    rts_long_a: assert property (O_MEM_REQ && op == 16'h4e75 |-> O_MEM_SIZE == 2'h2 && !O_MEM_WE)
        else $error("bad return pop");
    bcd_byte_a: assert property (O_MEM_REQ && op[15:12] == 4'h8 |-> O_MEM_SIZE == 2'h0)
        else $error("decimal access not byte");
    scc_read_a: assert property (O_MEM_REQ && O_MEM_WE && op[15:12] == 4'h5 |-> rd_seen)
        else $error("write without prior read");
    rtr_step_a: assert property (O_MEM_REQ && I_MEM_ACK && op == 16'h4e77 && O_MEM_SIZE == 2'h1
        |=> O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h2 && O_MEM_SIZE == 2'h2)
        else $error("bad second pop");
    cover property (O_ILLEGAL);
    cover property (O_DONE && op == 16'h4e77);
    cover property (O_MEM_REQ && O_MEM_WE && op[15:12] == 4'h5);
endmodule // exec_checker

/* File: tb/exec_memory_model.sv */
module exec_memory_model (
    input wire logic clk, req, we, // Clock and request
    input wire logic [31:0] addr, wdata, // Access
    input wire logic [1:0] dly, // Wait cycles
    output logic ack = 0, // Acknowledge
    output logic [31:0] rdata = 0 // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] m [logic [31:0]];
    logic [1:0] cnt = 0;
    // Answer after dly cycles; data toggles outside ack
    always @(posedge clk) begin
        ack <= 0;
        rdata <= ~rdata;
        if (req && !ack) begin
            cnt <= cnt + 1;
            if (cnt == dly) begin
                ack <= 1;
                cnt <= 0;
                rdata <= m.exists(addr) ? m[addr] : 32'h0;
                if (we) m[addr] = wdata;
            end
        end
    end
endmodule // exec_memory_model

/* File: tb/return_bcd_setcond_subtract_exec_bench.sv */
module return_bcd_setcond_subtract_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_MCLK = 0, I_SRST = 1, I_START = 0, I_SR_WE = 0, I_REG_WE = 0, ill;
    logic [15:0] I_OPCODE = 0, I_SR_WDATA = 0;
    logic [31:0] I_EA_ADDR = 0, I_IMM_DATA = 0, I_REG_WDATA = 0, v, a, b, r;
    logic [3:0] I_REG_ADDR = 0;
    logic [1:0] dly = 0;
    logic [4:0] f;
    wire [31:0] O_REG_RDATA, O_MEM_ADDR, O_MEM_WDATA, O_PC, I_MEM_RDATA;
    wire [15:0] O_SR;
    wire [1:0] O_MEM_SIZE;
    wire O_MEM_REQ, O_MEM_WE, O_BUSY, O_DONE, O_ILLEGAL, I_MEM_ACK;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, w;
    localparam logic [15:0] BAD[4] = '{16'h9009, 16'h9100, 16'h50c8, 16'h50fc};
    return_bcd_setcond_subtract_exec i_dut (.*);
    exec_memory_model i_mem (.clk(I_MCLK), .req(O_MEM_REQ), .we(O_MEM_WE), .addr(O_MEM_ADDR),
        .wdata(O_MEM_WDATA), .dly(dly), .ack(I_MEM_ACK), .rdata(I_MEM_RDATA));
    // Clock and hang limit
    always #2.5 I_MCLK = ~I_MCLK;
    always @(posedge I_MCLK) if (++cycles == 20000) begin n_mismatch++; results(); end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin n_mismatch++; $display("BAD %s exp %h seen %h", what, exp, seen); end
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge I_MCLK) begin I_REG_WE <= 1; I_REG_ADDR <= i; I_REG_WDATA <= d; end
        @(posedge I_MCLK) I_REG_WE <= 0;
    endtask
    task automatic sr(input logic [15:0] d);
        @(posedge I_MCLK) begin I_SR_WE <= 1; I_SR_WDATA <= d; end
        @(posedge I_MCLK) I_SR_WE <= 0;
    endtask
    task automatic rd(input logic [3:0] i);
        @(posedge I_MCLK) I_REG_ADDR <= i;
        repeat (2) @(posedge I_MCLK);
        #1 v = O_REG_RDATA;
    endtask
    task automatic run(input logic [15:0] op, input logic [31:0] imm);
        @(posedge I_MCLK) begin I_START <= 1; I_OPCODE <= op; I_EA_ADDR <= 32'h4000; I_IMM_DATA <= imm; end
        for (int k = 0; k < 200; k++) begin
            @(posedge I_MCLK) I_START <= 0;
            #1 ill = O_ILLEGAL;
            if (O_DONE === 1'b1 || ill === 1'b1) break;
        end
    endtask
    function automatic logic [8:0] bcd(input logic [7:0] d, s, input logic x);
        int t;
        t = d[7:4] * 10 + d[3:0] - s[7:4] * 10 - s[3:0] - x;
        return {t < 0, 8'((t + 100) % 100 / 10 * 16 + (t + 100) % 10)};
    endfunction
    function automatic logic [36:0] sub(input logic [31:0] d, s, input int w);
        longint m, x, q;
        m = (64'h1 << w) - 1;
        x = d & m;
        q = x - (s & m);
        return {q[63], q[w-1], (q & m) == 0, 1'(((x ^ s) & (x ^ q)) >> (w - 1)), q[63], 32'(q & m)};
    endfunction
    function automatic logic cond(input logic [3:0] c, input logic [4:0] f);
        logic nv;
        nv = f[3] ^ f[1];
        return {f[2] | nv, !f[2] & !nv, nv, !nv, f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0],
            f[0] | f[2], !f[0] & !f[2], 1'b0, 1'b1} >> c;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h61fc));
        repeat (6) @(posedge I_MCLK);
        I_SRST <= 0;
        sr(16'h2700);
        wr(4'hf, 32'h1000);
        i_mem.m[32'h1000] = 32'h00ff;
        i_mem.m[32'h1002] = 32'h12345678;
        i_mem.m[32'h1006] = 32'hcafe0000;
        run(16'h4e77, 0);
        chk(O_SR, 16'h271f, "sr");
        chk(O_PC, 32'h12345678, "pc");
        rd(4'hf);
        chk(v, 32'h1006, "sp");
        dly <= 2;
        run(16'h4e75, 0);
        chk(O_PC, 32'hcafe0000, "pc");
        rd(4'hf);
        chk(v, 32'h100a, "sp");
        $display("returns done");
        for (int i = 0; i < 6; i++) begin
            a = $urandom % 10 * 16 + $urandom % 10;
            b = $urandom % 10 * 16 + $urandom % 10;
            f = $urandom;
            sr({11'h0, f});
            wr(1, {24'habcdef, a[7:0]});
            wr(2, b);
            r = bcd(a[7:0], b[7:0], f[4]);
            run(16'h8302, 0);
            rd(1);
            chk(v, {24'habcdef, r[7:0]}, "bcd");
            chk(O_SR[4:0], {r[8], f[3], f[2] & (r[7:0] == 0), f[1], r[8]}, "bcdflags");
        end
        sr(16'h0014);
        wr(9, 32'h2001);
        wr(10, 32'h3001);
        i_mem.m[32'h2000] = 32'h15;
        i_mem.m[32'h3000] = 32'h42;
        run(16'h8509, 0);
        chk(i_mem.m[32'h3000][7:0], 8'h26, "bcdmem");
        chk(O_SR[4:0], 5'h00, "bcdmemflags");
        rd(9);
        chk(v, 32'h2000, "src");
        $display("decimal done");
        for (int c = 0; c < 16; c++) begin
            f = $urandom;
            sr({11'h0, f});
            wr(3, 32'h55555555);
            run(16'h50c3 | 16'(c << 8), 0);
            rd(3);
            chk(v, {24'h555555, {8{cond(c, f)}}}, "scc");
            chk(O_SR[4:0], f, "sccflags");
        end
        sr(16'h0004);
        run(16'h57d0, 0);
        chk(i_mem.m[32'h4000][7:0], 8'hff, "sccmem");
        $display("set on condition done");
        for (int i = 0; i < 6; i++) begin
            a = $urandom;
            b = (i == 5) ? a : $urandom;
            w = 8 << (i % 3);
            wr(4, a);
            wr(5, b);
            {f, r} = sub(a, b, w);
            run(16'h9805 | 16'((i % 3) << 6), 0);
            rd(4);
            chk(v, (a & ~((32'h1 << w) - 1)) | r, "sub");
            chk(O_SR[4:0], f, "subflags");
        end
        wr(4, 32'h10);
        run(16'h98bc, 32'h11);
        chk(O_SR[4:0], 5'h19, "subimm");
        i_mem.m[32'h4000] = 32'h5;
        {f, r} = sub(32'h5, 32'hffffffff, 16);
        run(16'h9950, 0);
        chk(i_mem.m[32'h4000][15:0], r[15:0], "submem");
        chk(O_SR[4:0], f, "submemflags");
        foreach (BAD[i]) begin
            run(BAD[i], 0);
            chk(ill, 1'b1, "illegal");
        end
        $display("subtract done");
        results();
    end
endmodule // return_bcd_setcond_subtract_exec_bench
bind return_bcd_setcond_subtract_exec exec_checker i_chk (.*);
